// [include/tbp_map.svh]
// Constants of the TypeB block protocol layer: frame limits, PCB codes,
// CRC_B figures and subcarrier timing.
// Assumes a 50 MHz core clock.
`ifndef TBP_MAP_SVH
`define TBP_MAP_SVH

// Frame limits
`define TBP_MAX_FIELD 9'd256
`define TBP_INF_MAX 9'd253
`define TBP_CHAIN_MIN 9'd64
`define TBP_MIN_FIELD 9'd3
`define TBP_SOF_ZEROS 4'd10
`define TBP_SOF_BITS 4'd12
`define TBP_EOF_ZEROS 4'd10
`define TBP_CHAR_BITS 4'd10

// Protocol control byte codes
`define TBP_PCB_I 8'h02
`define TBP_PCB_ACK 8'ha2
`define TBP_PCB_DESEL 8'hc2
`define TBP_PCB_CHAIN_BIT 4
`define TBP_PCB_NAK_BIT 4

// CRC_B, reflected form
`define TBP_CRC_INIT 16'hffff
`define TBP_CRC_POLY 16'h8408
`define TBP_CRC_RESID 16'hf0b8

// Subcarrier timing
`define TBP_CLK_HZ 50000000
`define TBP_SUB_HZ 848000
`define TBP_SUB_HALF (`TBP_CLK_HZ / (2 * `TBP_SUB_HZ))

`endif

// [include/tbp_pkg.sv]
// Types of the TypeB block protocol layer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package tbp_pkg;

    // One INF byte with framing marks
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic chain;
    } tbp_byte_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_WAIT = 2'b01,
        RX_CHAR = 2'b10
    } tbp_rx_st_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SOF = 2'b01,
        TX_CHAR = 2'b10,
        TX_EOF = 2'b11
    } tbp_tx_st_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELIV = 3'b001,
        ST_WRSP = 3'b010,
        ST_TX = 3'b011,
        ST_DESEL = 3'b100
    } tbp_st_t;

endpackage

`default_nettype wire

// [logic/tbp_mem.sv]
// Frame byte memory, one write port, one registered read port.
// Assumes a single clock; read data hold until the next read.
`default_nettype none

module tbp_mem #(
    parameter int DW = 8,
    parameter int AW = 8
) (
    // Clock
    input wire logic i_clk,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read port
    input wire logic i_re,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);

    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_re)
        begin
            o_rdata <= mem_q[i_raddr];
        end
    end

endmodule // tbp_mem

`default_nettype wire

// [logic/tbp_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes a synchronous active-low reset on the same clock.
`default_nettype none

module tbp_buf2 #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);

    logic [W-1:0] ent_q [0:1];
    logic [1:0] cnt_q;
    logic rp_q, wp_q;
    logic push, pop;

    assign o_ready = (cnt_q != 2'd2);
    assign o_valid = (cnt_q != 2'd0);
    assign o_data = ent_q[rp_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            ent_q[wp_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            cnt_q <= 2'd0;
            rp_q <= 1'b0;
            wp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
        end
    end

endmodule // tbp_buf2

`default_nettype wire

// [logic/tbp_top.sv]
// Card-side TypeB block protocol layer: character and frame coding,
// block decode, block numbering, chaining and deselect.
// Assumes a demodulator giving NRZ bits with the reader's bit clock, and
// a command layer on the core clock.
`default_nettype none
`include "tbp_map.svh"

module tbp_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Link from demodulator
    input wire logic i_lnk_clk,
    input wire logic i_lnk_data,
    // Link to modulator
    output logic o_tx_bit,
    output logic o_tx_mod,
    output logic o_tx_active,
    // Activation and status
    input wire logic i_activate,
    output logic o_deselected,
    output logic o_drop,
    // Command stream out
    output tbp_pkg::tbp_byte_t o_cmd_data,
    output logic o_cmd_valid,
    input wire logic i_cmd_ready,
    // Response stream in
    input wire tbp_pkg::tbp_byte_t i_rsp_data,
    input wire logic i_rsp_valid,
    output logic o_rsp_ready
);
    import tbp_pkg::*;

    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `TBP_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link synchronisers
    logic lc_s1_q, lc_s2_q, lc_s3_q, ld_s1_q, ld_s2_q;
    logic tick;

    always_ff @(posedge i_clk)
    begin
        lc_s1_q <= i_lnk_clk;
        lc_s2_q <= lc_s1_q;
        lc_s3_q <= lc_s2_q;
        ld_s1_q <= i_lnk_data;
        ld_s2_q <= ld_s1_q;
    end

    assign tick = lc_s2_q && !lc_s3_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive framing
    tbp_rx_st_t rx_st_q;
    logic [3:0] rx_zc_q, rx_bc_q;
    logic [7:0] rx_sh_q, rx_wd_q, rx_pcb_q;
    logic [8:0] rx_cnt_q;
    logic [15:0] rx_crc_q;
    logic rx_ovf_q, rx_end_q, rx_we_q;
    logic [7:0] rx_wa_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            rx_st_q <= RX_HUNT;
            rx_zc_q <= 4'h0;
            rx_bc_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 9'h000;
            rx_crc_q <= `TBP_CRC_INIT;
            rx_ovf_q <= 1'b0;
            rx_end_q <= 1'b0;
            rx_we_q <= 1'b0;
            rx_wa_q <= 8'h00;
            rx_wd_q <= 8'h00;
            rx_pcb_q <= 8'h00;
        end
        else
        begin
            rx_end_q <= 1'b0;
            rx_we_q <= 1'b0;
            if (tick)
            begin
                case (rx_st_q)
                    RX_HUNT:
                    begin
                        if (!ld_s2_q && rx_zc_q != 4'hf)
                            rx_zc_q <= rx_zc_q + 4'h1;
                        else if (ld_s2_q)
                        begin
                            rx_zc_q <= 4'h0;
                            if (rx_zc_q >= `TBP_SOF_ZEROS)
                            begin
                                rx_st_q <= RX_WAIT;
                                rx_cnt_q <= 9'h000;
                                rx_crc_q <= `TBP_CRC_INIT;
                                rx_ovf_q <= 1'b0;
                            end
                        end
                    end
                    RX_WAIT:
                    begin
                        if (!ld_s2_q)
                        begin
                            rx_st_q <= RX_CHAR;
                            rx_bc_q <= 4'h0;
                        end
                    end
                    RX_CHAR:
                    begin
                        rx_bc_q <= rx_bc_q + 4'h1;
                        if (rx_bc_q < 4'd8)
                            rx_sh_q <= {ld_s2_q, rx_sh_q[7:1]};
                        else if (ld_s2_q)
                        begin
                            rx_st_q <= RX_WAIT;
                            if (rx_cnt_q == `TBP_MAX_FIELD)
                                rx_ovf_q <= 1'b1;
                            else
                            begin
                                rx_we_q <= 1'b1;
                                rx_wa_q <= rx_cnt_q[7:0];
                                rx_wd_q <= rx_sh_q;
                                rx_cnt_q <= rx_cnt_q + 9'h001;
                                rx_crc_q <= crc_upd(rx_crc_q, rx_sh_q);
                                if (rx_cnt_q == 9'h000)
                                    rx_pcb_q <= rx_sh_q;
                            end
                        end
                        else
                        begin
                            // Zero byte with low stop is the EOF
                            rx_st_q <= RX_HUNT;
                            rx_zc_q <= 4'h0;
                            rx_end_q <= (rx_sh_q == 8'h00);
                        end
                    end
                    default:
                        rx_st_q <= RX_HUNT;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame memories and command buffer
    tbp_st_t st_q;
    logic [8:0] rd_a_q, inf_len_q, wcnt_q, tx_len_q, last_len_q, tx_i_q;
    logic rd_pend_q, pend_last_q, chain_in_q;
    logic [7:0] rx_rdata, tx_rdata, tx_pcb_q, last_pcb_q;
    logic rd_issue, push, buf_ready, rsp_take;
    tbp_byte_t buf_in;

    assign push = rd_pend_q && buf_ready;
    assign rd_issue = (st_q == ST_DELIV) && (rd_a_q <= inf_len_q)
                      && (!rd_pend_q || push);
    assign buf_in = '{data: rx_rdata, last: pend_last_q, chain: chain_in_q};
    assign o_rsp_ready = (st_q == ST_WRSP);
    assign rsp_take = i_rsp_valid && o_rsp_ready;

    tbp_mem #(.DW(8), .AW(8)) u_rx_mem (
        .i_clk(i_clk),
        .i_we(rx_we_q),
        .i_waddr(rx_wa_q),
        .i_wdata(rx_wd_q),
        .i_re(rd_issue),
        .i_raddr(rd_a_q[7:0]),
        .o_rdata(rx_rdata)
    );

    tbp_mem #(.DW(8), .AW(8)) u_tx_mem (
        .i_clk(i_clk),
        .i_we(rsp_take),
        .i_waddr(wcnt_q[7:0]),
        .i_wdata(i_rsp_data.data),
        .i_re(1'b1),
        .i_raddr(8'(tx_i_q - 9'h001)),
        .o_rdata(tx_rdata)
    );

    // A stalled command layer fills this and pauses the memory reads
    tbp_buf2 #(.W($bits(tbp_byte_t))) u_cmd_buf (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_valid(rd_pend_q),
        .i_data(buf_in),
        .o_ready(buf_ready),
        .o_valid(o_cmd_valid),
        .o_data(o_cmd_data),
        .i_ready(i_cmd_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Block control
    logic bn_q, tx_go_q, tx_done_q, desel_pend_q, have_last_q, drop_q;
    logic good;
    logic [8:0] rx_inf;

    assign rx_inf = rx_cnt_q - `TBP_MIN_FIELD;
    assign good = (rx_crc_q == `TBP_CRC_RESID) && !rx_ovf_q
                  && (rx_cnt_q >= `TBP_MIN_FIELD);
    assign o_deselected = (st_q == ST_DESEL);
    assign o_drop = drop_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || i_activate)
        begin
            st_q <= ST_IDLE;
            bn_q <= 1'b1;
            rd_a_q <= 9'h000;
            rd_pend_q <= 1'b0;
            pend_last_q <= 1'b0;
            inf_len_q <= 9'h000;
            chain_in_q <= 1'b0;
            wcnt_q <= 9'h000;
            tx_go_q <= 1'b0;
            tx_pcb_q <= 8'h00;
            tx_len_q <= 9'h000;
            last_pcb_q <= 8'h00;
            last_len_q <= 9'h000;
            have_last_q <= 1'b0;
            desel_pend_q <= 1'b0;
            drop_q <= 1'b0;
        end
        else
        begin
            tx_go_q <= 1'b0;
            drop_q <= rx_end_q && !(good && st_q == ST_IDLE);
            if (rd_issue)
            begin
                rd_a_q <= rd_a_q + 9'h001;
                pend_last_q <= (rd_a_q == inf_len_q);
            end
            if (rd_issue)
                rd_pend_q <= 1'b1;
            else if (push)
                rd_pend_q <= 1'b0;
            case (st_q)
                ST_IDLE:
                begin
                    if (rx_end_q && good)
                    begin
                        if (rx_pcb_q[7:6] == 2'b00)
                        begin
                            // Short chained blocks are not accepted
                            if (!(rx_pcb_q[`TBP_PCB_CHAIN_BIT]
                                  && rx_inf < `TBP_CHAIN_MIN))
                            begin
                                bn_q <= ~bn_q;
                                chain_in_q <= rx_pcb_q[`TBP_PCB_CHAIN_BIT];
                                inf_len_q <= rx_inf;
                                rd_a_q <= 9'h001;
                                wcnt_q <= 9'h000;
                                st_q <= (rx_inf != 9'h000) ? ST_DELIV
                                        : ST_WRSP;
                            end
                        end
                        else if (rx_pcb_q[7:6] == 2'b10)
                        begin
                            if (rx_pcb_q[0] == bn_q)
                            begin
                                if (have_last_q)
                                begin
                                    tx_pcb_q <= last_pcb_q;
                                    tx_len_q <= last_len_q;
                                    tx_go_q <= 1'b1;
                                    st_q <= ST_TX;
                                end
                            end
                            else if (rx_pcb_q[`TBP_PCB_NAK_BIT])
                            begin
                                tx_pcb_q <= `TBP_PCB_ACK | {7'h00, bn_q};
                                tx_len_q <= 9'h000;
                                tx_go_q <= 1'b1;
                                st_q <= ST_TX;
                            end
                            else if (last_pcb_q[`TBP_PCB_CHAIN_BIT])
                            begin
                                bn_q <= ~bn_q;
                                wcnt_q <= 9'h000;
                                st_q <= ST_WRSP;
                            end
                        end
                        else if (rx_pcb_q[5:4] == 2'b00)
                        begin
                            tx_pcb_q <= `TBP_PCB_DESEL;
                            tx_len_q <= 9'h000;
                            tx_go_q <= 1'b1;
                            desel_pend_q <= 1'b1;
                            st_q <= ST_TX;
                        end
                    end
                end
                ST_DELIV:
                begin
                    if (push && pend_last_q)
                    begin
                        wcnt_q <= 9'h000;
                        if (chain_in_q)
                        begin
                            tx_pcb_q <= `TBP_PCB_ACK | {7'h00, bn_q};
                            tx_len_q <= 9'h000;
                            tx_go_q <= 1'b1;
                            st_q <= ST_TX;
                        end
                        else
                            st_q <= ST_WRSP;
                    end
                end
                ST_WRSP:
                begin
                    if (rsp_take)
                    begin
                        wcnt_q <= wcnt_q + 9'h001;
                        if (i_rsp_data.last
                            || wcnt_q == `TBP_INF_MAX - 9'h001)
                        begin
                            // Only an I-block reply here, never WTX
                            tx_pcb_q <= `TBP_PCB_I | {7'h00, bn_q}
                                | {3'h0, i_rsp_data.chain
                                   && wcnt_q >= `TBP_CHAIN_MIN - 9'h001,
                                   4'h0};
                            last_pcb_q <= `TBP_PCB_I | {7'h00, bn_q}
                                | {3'h0, i_rsp_data.chain
                                   && wcnt_q >= `TBP_CHAIN_MIN - 9'h001,
                                   4'h0};
                            tx_len_q <= wcnt_q + 9'h001;
                            last_len_q <= wcnt_q + 9'h001;
                            have_last_q <= 1'b1;
                            tx_go_q <= 1'b1;
                            st_q <= ST_TX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (tx_done_q)
                    begin
                        st_q <= desel_pend_q ? ST_DESEL : ST_IDLE;
                        desel_pend_q <= 1'b0;
                    end
                end
                ST_DESEL:
                    st_q <= ST_DESEL;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit framing
    tbp_tx_st_t tx_st_q;
    logic [3:0] tb_q;
    logic [9:0] tsh_q;
    logic [15:0] tcrc_q;
    logic [7:0] cur_byte;

    always_comb
    begin
        if (tx_i_q == 9'h000)
            cur_byte = tx_pcb_q;
        else if (tx_i_q <= tx_len_q)
            cur_byte = tx_rdata;
        else if (tx_i_q == tx_len_q + 9'h001)
            cur_byte = ~tcrc_q[7:0];
        else
            cur_byte = ~tcrc_q[15:8];
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            tx_st_q <= TX_IDLE;
            tb_q <= 4'h0;
            tx_i_q <= 9'h000;
            tsh_q <= 10'h3ff;
            tcrc_q <= `TBP_CRC_INIT;
            o_tx_bit <= 1'b1;
            tx_done_q <= 1'b0;
        end
        else
        begin
            tx_done_q <= 1'b0;
            if (tx_go_q)
            begin
                tx_st_q <= TX_SOF;
                tb_q <= 4'h0;
                tx_i_q <= 9'h000;
                tcrc_q <= `TBP_CRC_INIT;
            end
            else if (tick)
            begin
                tb_q <= tb_q + 4'h1;
                case (tx_st_q)
                    TX_SOF:
                    begin
                        o_tx_bit <= (tb_q >= `TBP_SOF_ZEROS);
                        if (tb_q == `TBP_SOF_BITS - 4'h1)
                        begin
                            tx_st_q <= TX_CHAR;
                            tb_q <= 4'h0;
                            tsh_q <= {1'b1, cur_byte, 1'b0};
                            tcrc_q <= crc_upd(tcrc_q, cur_byte);
                            tx_i_q <= tx_i_q + 9'h001;
                        end
                    end
                    TX_CHAR:
                    begin
                        o_tx_bit <= tsh_q[0];
                        tsh_q <= {1'b1, tsh_q[9:1]};
                        if (tb_q == `TBP_CHAR_BITS - 4'h1)
                        begin
                            tb_q <= 4'h0;
                            if (tx_i_q == tx_len_q + `TBP_MIN_FIELD)
                                tx_st_q <= TX_EOF;
                            else
                            begin
                                tsh_q <= {1'b1, cur_byte, 1'b0};
                                if (tx_i_q <= tx_len_q)
                                    tcrc_q <= crc_upd(tcrc_q, cur_byte);
                                tx_i_q <= tx_i_q + 9'h001;
                            end
                        end
                    end
                    TX_EOF:
                    begin
                        o_tx_bit <= (tb_q == `TBP_EOF_ZEROS);
                        if (tb_q == `TBP_EOF_ZEROS)
                        begin
                            tx_st_q <= TX_IDLE;
                            tx_done_q <= 1'b1;
                        end
                    end
                    default:
                        o_tx_bit <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Subcarrier and BPSK; 50 MHz gives the nearest rate, not exact
    logic [5:0] sub_cnt_q;
    logic sub_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            sub_cnt_q <= 6'h00;
            sub_q <= 1'b0;
            o_tx_mod <= 1'b0;
            o_tx_active <= 1'b0;
        end
        else
        begin
            if (sub_cnt_q == 6'(`TBP_SUB_HALF - 1))
            begin
                sub_cnt_q <= 6'h00;
                sub_q <= ~sub_q;
            end
            else
                sub_cnt_q <= sub_cnt_q + 6'h01;
            o_tx_active <= (tx_st_q != TX_IDLE);
            o_tx_mod <= (tx_st_q != TX_IDLE) && (sub_q ^ ~o_tx_bit);
        end
    end

endmodule // tbp_top

`default_nettype wire

// [testbench/tbp_top_sva.sv]
// Port checker of the block protocol layer.
// Assumes binding onto every tbp_top instance.
`default_nettype none
module tbp_top_sva (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Observed ports
    input wire logic o_tx_bit,
    input wire logic o_tx_mod,
    input wire logic o_tx_active,
    input wire logic i_activate,
    input wire logic o_deselected,
    input wire logic o_drop,
    input wire tbp_pkg::tbp_byte_t o_cmd_data,
    input wire logic o_cmd_valid,
    input wire logic i_cmd_ready,
    input wire logic o_rsp_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    import tbp_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////
    chk_tx_idle: assert property (
        $fell(o_tx_active) |=> o_tx_bit && !o_tx_mod) else $error("tx idle");
    chk_drop_pulse: assert property (
        o_drop |=> !o_drop) else $error("drop pulse");
    chk_desel_hold: assert property (
        o_deselected && !i_activate |=> o_deselected) else $error("desel");
    chk_act_clear: assert property (
        i_activate |=> !o_deselected) else $error("activate");
    chk_desel_rise: assert property (
        $rose(o_deselected) |-> !o_tx_active) else $error("desel rise");
    chk_desel_quiet: assert property (
        o_deselected |-> !o_rsp_ready && !o_cmd_valid) else $error("quiet");
    chk_tx_no_rsp: assert property (
        o_tx_active |-> !o_rsp_ready) else $error("rsp in tx");
    chk_cmd_hold: assert property (
        o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd_data))
        else $error("cmd hold");
    cover property (o_drop);
    cover property ($rose(o_deselected));
    cover property (o_cmd_valid && i_cmd_ready);
endmodule // tbp_top_sva
bind tbp_top tbp_top_sva tbp_top_sva_inst (.i_clk, .i_resetn, .o_tx_bit,
    .o_tx_mod, .o_tx_active, .i_activate, .o_deselected, .o_drop,
    .o_cmd_data, .o_cmd_valid, .i_cmd_ready, .o_rsp_ready);
`default_nettype wire

// [testbench/tbp_rdr_model.sv]
// Reader model: frames bytes onto the link and records the reply bits.
// Assumes a card that answers on the ticks of this link clock.
`default_nettype none
module tbp_rdr_model (
    // Link to card
    output var logic o_lnk_clk,
    output var logic o_lnk_data,
    // Link from card
    input wire logic i_tx_bit,
    input wire logic i_tx_active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rxq[$];
    initial o_lnk_clk = 0;
    initial o_lnk_data = 1;
    // Clock stands low between frames; reply kept from its first zero
    task automatic tick(input logic b);
        o_lnk_data = b;
        #80;
        if (i_tx_active === 1'b1 && (rxq.size() > 0 || i_tx_bit === 1'b0))
            rxq.push_back(i_tx_bit);
        o_lnk_clk = 1;
        #80;
        o_lnk_clk = 0;
    endtask
    ////////////////////////////////////////
    // No CID or NAD is ever placed after the PCB
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = 16'hffff;
        foreach (f[i])
        begin
            c ^= {8'h00, f[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        c = ~c ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        rxq.delete();
        repeat (10) tick(0);
        repeat (2) tick(1);
        foreach (f[i])
        begin
            tick(0);
            for (int k = 0; k < 8; k++) tick(f[i][k]);
            tick(1);
        end
        repeat (10) tick(0);
        o_lnk_data = 1;
    endtask
    // Toggling data while listening: no stale level to lean on
    task automatic listen(input int n);
        repeat (n) tick(~o_lnk_data);
    endtask
endmodule // tbp_rdr_model
`default_nettype wire

// [testbench/tbp_top_tb.sv]
// Bench of the block protocol layer with a reader model on the link.
// Assumes package, design, model and checker compiled before it.
`default_nettype none
module tbp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tbp_pkg::*;
    logic i_clk = 0, i_resetn = 0, i_activate = 0, i_cmd_ready = 0;
    logic i_rsp_valid = 0, lclk, ldat;
    logic o_tx_bit, o_tx_mod, o_tx_active, o_deselected, o_drop;
    logic o_cmd_valid, o_rsp_ready;
    tbp_byte_t i_rsp_data = '0, o_cmd_data;
    int n_errors = 0, samples_checked = 0;
    always #10 i_clk = ~i_clk;
    tbp_top tbp_top_inst (.i_clk, .i_resetn, .i_lnk_clk(lclk),
        .i_lnk_data(ldat), .o_tx_bit, .o_tx_mod, .o_tx_active, .i_activate,
        .o_deselected, .o_drop, .o_cmd_data, .o_cmd_valid, .i_cmd_ready,
        .i_rsp_data, .i_rsp_valid, .o_rsp_ready);
    tbp_rdr_model tbp_rdr_model_inst (.o_lnk_clk(lclk), .o_lnk_data(ldat),
        .i_tx_bit(o_tx_bit), .i_tx_active(o_tx_active));
    ////////////////////////////////////////
    task automatic complete_run();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic await(ref logic s);
        int k;
        for (k = 0; k < 4000 && s !== 1'b1; k++) @(posedge i_clk);
        if (k == 4000)
        begin
            n_errors++;
            complete_run();
        end
    endtask
    // Reply character k, start bit in bit 0; k of -1 ends the SOF
    function automatic logic [9:0] chr(input int k);
        logic [9:0] v;
        for (int i = 0; i < 10; i++)
            v[i] = tbp_rdr_model_inst.rxq[12 + 10 * k + i];
        return v;
    endfunction
    task automatic pop(input logic [7:0] d, input logic l);
        @(posedge i_clk);
        i_cmd_ready <= 1;
        @(posedge i_clk);
        await(o_cmd_valid);
        cmp({o_cmd_data.data, o_cmd_data.last}, {d, l});
        i_cmd_ready <= 0;
    endtask
    task automatic sl(input logic [7:0] f[$], input int n);
        tbp_rdr_model_inst.send(f, 0);
        tbp_rdr_model_inst.listen(n);
    endtask
    ////////////////////////////////////////
    task automatic t_iblk();
        tbp_rdr_model_inst.send('{8'h02, 8'h11, 8'h22}, 0);
        await(o_cmd_valid);
        repeat (4) @(posedge i_clk);
        pop(8'h11, 0);
        pop(8'h22, 1);
        i_rsp_data <= '{8'h5a, 1'b1, 1'b0};
        i_rsp_valid <= 1;
        @(posedge i_clk);
        await(o_rsp_ready);
        i_rsp_valid <= 0;
        tbp_rdr_model_inst.listen(90);
        cmp(chr(-1), 10'h300);
        cmp(chr(0), {1'b1, 8'h02, 1'b0});
        cmp(chr(1), {1'b1, 8'h5a, 1'b0});
        $display("t_iblk end");
    endtask
    task automatic t_crc();
        tbp_rdr_model_inst.send('{8'h12, 8'h44}, 0);
        tbp_rdr_model_inst.send('{8'h02, 8'h33}, 1);
        await(o_drop);
        repeat (4) @(posedge i_clk);
        cmp(o_cmd_valid, 0);
        $display("t_crc end");
    endtask
    task automatic t_rblk();
        sl('{8'hb3}, 70);
        cmp(chr(0), {1'b1, 8'ha2, 1'b0});
        cmp(chr(3), 10'h000);
        sl('{8'ha2}, 90);
        cmp(chr(0), {1'b1, 8'h02, 1'b0});
        cmp(chr(1), {1'b1, 8'h5a, 1'b0});
        $display("t_rblk end");
    endtask
    task automatic t_desel();
        sl('{8'hc2}, 70);
        cmp(chr(0), {1'b1, 8'hc2, 1'b0});
        await(o_deselected);
        cmp(o_deselected, 1);
        @(posedge i_clk);
        i_activate <= 1;
        @(posedge i_clk);
        i_activate <= 0;
        repeat (2) @(posedge i_clk);
        cmp(o_deselected, 0);
        $display("t_desel end");
    endtask
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1;
        repeat (4) @(posedge i_clk);
        t_iblk();
        t_crc();
        t_rblk();
        t_desel();
        complete_run();
    end
endmodule // tbp_top_tb
`default_nettype wire
